// ---- inc/sram_wr_map.svh ----
/*
 holds timing figures and widths for the static ram write controller.
 assumes a 20 MHz system clock (50 ns period).
*/
`ifndef SRAM_WR_MAP_SVH
`define SRAM_WR_MAP_SVH
`define CLK_PERIOD_NS 50
`define ADDR_W 13
`define DATA_W 8
`define MEM_WORDS 8192
// grade 0 / 1 / 2 figures in ns
`define WC_NS_G0 100
`define WC_NS_G1 120
`define WC_NS_G2 150
`define WP_NS_G0 60
`define WP_NS_G1 70
`define WP_NS_G2 90
`define WR_NS_G0 15
`define WR_NS_G1 15
`define WR_NS_G2 20
`define DS_NS_G0 40
`define DS_NS_G1 50
`define DS_NS_G2 60
`define CW_NS_G0 80
`define CW_NS_G1 90
`define CW_NS_G2 110
`define AW_NS_G0 80
`define AW_NS_G1 90
`define AW_NS_G2 110
`define OTW_NS_G0 40
`define OTW_NS_G1 50
`define OTW_NS_G2 50
`define WX_NS_G0 5
`define WX_NS_G1 5
`define WX_NS_G2 10
`define RC_NS_G0 100
`define RC_NS_G1 120
`define RC_NS_G2 150
`define AS_NS 0
`define DH_NS 0
`define SU_NS 0
// least time in ns to whole cycles, never below one
`define CYC_MIN(ns) ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`endif

// ---- inc/sram_wr_pkg.sv ----
/*
 holds the types of the static ram write controller.
 assumes sram_wr_map.svh supplies the widths.
*/
`include "sram_wr_map.svh"
package sram_wr_pkg;
   typedef struct packed {
      logic [`ADDR_W-1:0] addr;
      logic [`DATA_W-1:0] data;
      logic write;
   } req_t;
   typedef struct packed {
      logic sel_low_n;
      logic sel_high;
      logic we_n;
      logic oe_n;
   } ctl_t;
   typedef enum logic [6:0] {
      st_idle = 7'h01,
      st_setup = 7'h02,
      st_strobe = 7'h04,
      st_recover = 7'h08,
      st_read = 7'h10,
      st_retain = 7'h20,
      st_resume = 7'h40
   } state_t;
endpackage

// ---- design/sram_wr_timer.sv ----
/*
 holds a down counter that times each phase of a ram access.
 assumes the controller loads it on entering a phase.
*/
`timescale 1ns/1ps
module sram_wr_timer
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_load,
   input wire logic [3:0] i_count,
   output logic o_done
);
   logic [3:0] count;
   logic [3:0] next_count;
   always_comb
   begin
      next_count = count;
      if (i_load)
      begin
         next_count = i_count;
      end
      else if (count != 4'h0)
      begin
         next_count = count - 4'h1;
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         count <= 4'h0;
      end
      else if (i_ce)
      begin
         count <= next_count;
      end
   end
   // done on the last cycle of a phase, so a count of n spans n cycles;
   // it must not look at i_load, which the controller derives from o_done
   assign o_done = (count <= 4'h1);
endmodule

// ---- design/sram_wr_ctrl.sv ----
/*
 holds the host-side controller that drives an 8192 x 8 asynchronous
 static ram through its select, strobe, gate, address and data pins.
 assumes the ram pins are wired straight to this module and that the
 supply monitor tells it when low supply is coming and has gone.
*/
`timescale 1ns/1ps
module sram_wr_ctrl
#(
   parameter int GRADE = 0
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire sram_wr_pkg::req_t i_req,
   input wire logic i_req_valid,
   output logic o_req_ready,
   output logic [`DATA_W-1:0] o_rd_data,
   output logic o_rd_valid,
   input wire logic i_low_supply,
   output logic o_retained,
   output logic [`ADDR_W-1:0] o_addr,
   output sram_wr_pkg::ctl_t o_ctl,
   output logic [`DATA_W-1:0] o_dq,
   output logic o_dq_oe,
   input wire logic [`DATA_W-1:0] i_dq
);
   ////////////////////////////////////////////////////////////////////////////
   // grade-selected figures turned into cycle counts
   localparam int WC_NS = GRADE == 0 ? `WC_NS_G0 : GRADE == 1 ? `WC_NS_G1 : `WC_NS_G2;
   localparam int WP_NS = GRADE == 0 ? `WP_NS_G0 : GRADE == 1 ? `WP_NS_G1 : `WP_NS_G2;
   localparam int WR_NS = GRADE == 0 ? `WR_NS_G0 : GRADE == 1 ? `WR_NS_G1 : `WR_NS_G2;
   localparam int DS_NS = GRADE == 0 ? `DS_NS_G0 : GRADE == 1 ? `DS_NS_G1 : `DS_NS_G2;
   localparam int CW_NS = GRADE == 0 ? `CW_NS_G0 : GRADE == 1 ? `CW_NS_G1 : `CW_NS_G2;
   localparam int AW_NS = GRADE == 0 ? `AW_NS_G0 : GRADE == 1 ? `AW_NS_G1 : `AW_NS_G2;
   localparam int OTW_NS = GRADE == 0 ? `OTW_NS_G0 : GRADE == 1 ? `OTW_NS_G1 : `OTW_NS_G2;
   localparam int WX_NS = GRADE == 0 ? `WX_NS_G0 : GRADE == 1 ? `WX_NS_G1 : `WX_NS_G2;
   localparam int RC_NS = GRADE == 0 ? `RC_NS_G0 : GRADE == 1 ? `RC_NS_G1 : `RC_NS_G2;
   // strobe stays low for the longest of pulse, select, address, data setup
   localparam int P1 = WP_NS > CW_NS ? WP_NS : CW_NS;
   localparam int P2 = AW_NS > DS_NS ? AW_NS : DS_NS;
   localparam int P3 = P1 > P2 ? P1 : P2;
   localparam int PULSE_NS = P3 > OTW_NS ? P3 : OTW_NS;
   localparam int PULSE_CYC = `CYC_MIN(PULSE_NS);
   localparam int SETUP_CYC = `CYC_MIN(`AS_NS);
   // recovery covers both write recovery and the ram's own quiet time
   localparam int REC_NS = WR_NS > WX_NS ? WR_NS : WX_NS;
   localparam int REC_A = `CYC_MIN(REC_NS);
   localparam int REC_B = `CYC_MIN(WC_NS) - PULSE_CYC - SETUP_CYC;
   localparam int REC_CYC = REC_A > REC_B ? REC_A : REC_B;
   localparam int RC_CYC = `CYC_MIN(RC_NS);
   localparam logic [3:0] SETUP_L = 4'(SETUP_CYC);
   localparam logic [3:0] PULSE_L = 4'(PULSE_CYC);
   localparam logic [3:0] REC_L = 4'(REC_CYC);
   localparam logic [3:0] RC_L = 4'(RC_CYC);

   ////////////////////////////////////////////////////////////////////////////
   sram_wr_pkg::state_t state;
   sram_wr_pkg::state_t next_state;
   sram_wr_pkg::req_t cur;
   sram_wr_pkg::req_t next_cur;
   logic [`DATA_W-1:0] next_rd_data;
   logic next_rd_valid;
   logic load;
   logic [3:0] load_count;
   logic done;

   sram_wr_timer u_timer
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_load(load),
      .i_count(load_count),
      .o_done(done)
   );

   always_comb
   begin
      next_state = state;
      next_cur = cur;
      next_rd_data = o_rd_data;
      next_rd_valid = 1'b0;
      load = 1'b0;
      load_count = 4'h0;
      case (state)
         sram_wr_pkg::st_idle:
         begin
            if (i_low_supply)
            begin
               next_state = sram_wr_pkg::st_retain;
            end
            else if (i_req_valid)
            begin
               next_cur = i_req;
               next_state = sram_wr_pkg::st_setup;
               load = 1'b1;
               load_count = SETUP_L;
            end
         end
         sram_wr_pkg::st_setup:
         begin
            if (done)
            begin
               next_state = cur.write ? sram_wr_pkg::st_strobe : sram_wr_pkg::st_read;
               load = 1'b1;
               load_count = cur.write ? PULSE_L : RC_L;
            end
         end
         sram_wr_pkg::st_strobe:
         begin
            if (done)
            begin
               next_state = sram_wr_pkg::st_recover;
               load = 1'b1;
               load_count = REC_L;
            end
         end
         sram_wr_pkg::st_read:
         begin
            if (done)
            begin
               next_rd_data = i_dq;
               next_rd_valid = 1'b1;
               next_state = sram_wr_pkg::st_recover;
               load = 1'b1;
               load_count = REC_L;
            end
         end
         sram_wr_pkg::st_recover:
         begin
            if (done)
            begin
               next_state = sram_wr_pkg::st_idle;
            end
         end
         sram_wr_pkg::st_retain:
         begin
            if (!i_low_supply)
            begin
               next_state = sram_wr_pkg::st_resume;
               load = 1'b1;
               load_count = RC_L;
            end
         end
         sram_wr_pkg::st_resume:
         begin
            if (i_low_supply)
            begin
               next_state = sram_wr_pkg::st_retain;
            end
            else if (done)
            begin
               next_state = sram_wr_pkg::st_idle;
            end
         end
         default:
         begin
            next_state = sram_wr_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state <= sram_wr_pkg::st_idle;
         cur <= '0;
         o_rd_data <= '0;
         o_rd_valid <= 1'b0;
      end
      else if (i_ce)
      begin
         state <= next_state;
         cur <= next_cur;
         o_rd_data <= next_rd_data;
         o_rd_valid <= next_rd_valid;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins: address and data are held from the registered request through
   // recovery, so setup and zero hold are met on every edge
   logic sel_on;
   assign sel_on = (state == sram_wr_pkg::st_strobe) || (state == sram_wr_pkg::st_read);
   assign o_addr = cur.addr;
   assign o_ctl.sel_low_n = !sel_on;
   assign o_ctl.sel_high = sel_on;
   assign o_ctl.we_n = !(state == sram_wr_pkg::st_strobe);
   // gate held high while writing so the ram never drives into our data
   assign o_ctl.oe_n = !(state == sram_wr_pkg::st_read);
   assign o_dq = cur.data;
   // drive only around a write; never while the gate is open
   assign o_dq_oe = cur.write && ((state == sram_wr_pkg::st_setup) ||
      (state == sram_wr_pkg::st_strobe) || (state == sram_wr_pkg::st_recover));
   assign o_req_ready = (state == sram_wr_pkg::st_idle) && !i_low_supply;
   assign o_retained = (state == sram_wr_pkg::st_retain);
endmodule

// ---- bench/sram_wr_assertions.sv ----
/*
 checker for the pins of the static ram write controller.
 assumes i_ce is high while a strobe or a read is under way, so those
 states last their nominal cycles; a freeze in setup is allowed.
*/
`timescale 1ns/1ps
`include "sram_wr_map.svh"
module sram_wr_assertions
#(
   parameter int GRADE = 0
)
(
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic i_low_supply,
   input wire logic o_req_ready,
   input wire logic o_rd_valid,
   input wire logic o_retained,
   input wire logic [`ADDR_W-1:0] o_addr,
   input wire sram_wr_pkg::ctl_t o_ctl,
   input wire logic [`DATA_W-1:0] o_dq,
   input wire logic o_dq_oe
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////////
   property p_wr_sel;
      !o_ctl.we_n |-> !o_ctl.sel_low_n && o_ctl.sel_high;
   endproperty
   a_wr_sel: assert property (p_wr_sel) else $error("strobe without selects");
   property p_setup;
      $fell(o_ctl.we_n) |-> $stable(o_addr) && $past(o_dq_oe) && o_dq_oe;
   endproperty
   a_setup: assert property (p_setup) else $error("address or data late");
   // two cycles give 100 ns, which covers the 80 ns select and address figures
   property p_pulse;
      GRADE == 0 && $fell(o_ctl.we_n) |-> ##1 !o_ctl.we_n ##1 o_ctl.we_n;
   endproperty
   a_pulse: assert property (p_pulse) else $error("strobe width wrong");
   property p_hold;
      $rose(o_ctl.we_n) |-> o_dq_oe && $stable(o_dq) && !o_req_ready;
   endproperty
   a_hold: assert property (p_hold) else $error("data dropped at write end");
   property p_recover;
      $rose(o_ctl.we_n) |-> o_ctl.sel_low_n && !o_ctl.sel_high;
   endproperty
   a_recover: assert property (p_recover) else $error("selects kept after write");
   property p_no_fight;
      o_dq_oe |-> o_ctl.oe_n;
   endproperty
   a_no_fight: assert property (p_no_fight) else $error("bus fight on data");
   property p_supply;
      i_low_supply |-> !o_req_ready;
   endproperty
   a_supply: assert property (p_supply) else $error("ready in low supply");
   property p_retain;
      o_retained |-> o_ctl.sel_low_n && !o_ctl.sel_high && !o_dq_oe;
   endproperty
   a_retain: assert property (p_retain) else $error("ram selected in retention");
   property p_resume;
      $fell(o_retained) |-> !o_req_ready;
   endproperty
   a_resume: assert property (p_resume) else $error("no wait after retention");
   property p_read;
      GRADE == 0 && $fell(o_ctl.oe_n) |-> ##2 o_ctl.oe_n && o_rd_valid ##1 !o_rd_valid;
   endproperty
   a_read: assert property (p_read) else $error("read timing wrong");
endmodule
bind sram_wr_ctrl sram_wr_assertions #(.GRADE(GRADE)) chk (.i_clk_sys(i_clk_sys),
   .i_rst_n(i_rst_n), .i_low_supply(i_low_supply), .o_req_ready(o_req_ready),
   .o_rd_valid(o_rd_valid), .o_retained(o_retained), .o_addr(o_addr), .o_ctl(o_ctl),
   .o_dq(o_dq), .o_dq_oe(o_dq_oe));

// ---- bench/sram_model.sv ----
/*
 behavioural 8192 x 8 static ram seen from its pins.
 assumes the bench resolves the data bus and feeds it back in.
*/
`timescale 1ns/1ps
`include "sram_wr_map.svh"
module sram_model
(
   input wire logic i_clk_sys,
   input wire logic [`ADDR_W-1:0] i_addr,
   input wire sram_wr_pkg::ctl_t i_ctl,
   input wire logic [`DATA_W-1:0] i_bus,
   output logic [`DATA_W-1:0] o_pins
);
   logic [`DATA_W-1:0] mem [`MEM_WORDS];
   logic [`DATA_W-1:0] last = 8'h00;
   logic sel;
   assign sel = !i_ctl.sel_low_n && i_ctl.sel_high;
   // a floating bus shows the inverse of its last value, never a held copy
   assign o_pins = (sel && !i_ctl.oe_n && i_ctl.we_n) ? mem[i_addr] : ~last;
   always @(posedge i_clk_sys)
   begin
      last <= i_bus;
      if (sel && !i_ctl.we_n) mem[i_addr] <= i_bus;
   end
endmodule

// ---- bench/sram_wr_ctrl_tb_top.sv ----
/*
 self-checking bench for the static ram write controller.
 assumes grade 0 timing and the ram model on the far side.
*/
`timescale 1ns/1ps
`include "sram_wr_map.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
   $display("wrong value t=%0t got %h", $time, a); end end
module sram_wr_ctrl_tb_top;
   logic i_clk_sys, i_rst_n, i_req_valid, i_low_supply, i_ce;
   sram_wr_pkg::req_t i_req;
   sram_wr_pkg::ctl_t o_ctl;
   logic o_req_ready, o_rd_valid, o_retained, o_dq_oe;
   logic [`DATA_W-1:0] o_rd_data, o_dq, ram_pins, dq;
   logic [`ADDR_W-1:0] o_addr;
   int n_mismatch, n_tests, cyc;
   assign dq = o_dq_oe ? o_dq : ram_pins;
   sram_wr_ctrl #(.GRADE(0)) uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_req(i_req), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
      .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_low_supply(i_low_supply),
      .o_retained(o_retained), .o_addr(o_addr), .o_ctl(o_ctl), .o_dq(o_dq),
      .o_dq_oe(o_dq_oe), .i_dq(dq));
   sram_model ram (.i_clk_sys(i_clk_sys), .i_addr(o_addr), .i_ctl(o_ctl), .i_bus(dq),
      .o_pins(ram_pins));
   ////////////////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task access(input logic [12:0] a, input logic [7:0] d, input logic w);
      int k;
      @(posedge i_clk_sys);
      i_req <= '{a, d, w};
      i_req_valid <= 1'b1;
      k = 0;
      do
      begin
         @(negedge i_clk_sys);
         k++;
      end while (!o_req_ready && k < 40);
      @(posedge i_clk_sys);
      i_req_valid <= 1'b0;
   endtask
   task read_chk(input logic [12:0] a, input logic [7:0] e);
      int k;
      access(a, 8'h00, 1'b0);
      k = 0;
      do
      begin
         @(negedge i_clk_sys);
         k++;
      end while (!o_rd_valid && k < 20);
      `CHK(o_rd_valid, 1'b1)
      `CHK(o_rd_data, e)
   endtask
   task t_reset;
      `CHK(o_ctl, 4'hb)
      `CHK({o_dq_oe, o_req_ready}, 2'h1)
   endtask
   task t_write_read;
      logic [12:0] ad [3] = '{13'h0000, 13'h1fff, 13'h0aaa};
      logic [7:0] da [3] = '{8'h5a, 8'ha5, 8'h3c};
      for (int i = 0; i < 3; i++) access(ad[i], da[i], 1'b1);
      for (int i = 0; i < 3; i++) read_chk(ad[i], da[i]);
      access(13'h0000, 8'hc3, 1'b1);
      read_chk(13'h0000, 8'hc3);
   endtask
   task t_retain;
      @(posedge i_clk_sys);
      i_low_supply <= 1'b1;
      repeat (4) @(negedge i_clk_sys);
      `CHK({o_retained, o_req_ready, o_ctl.sel_high}, 3'h4)
      @(posedge i_clk_sys);
      i_low_supply <= 1'b0;
      read_chk(13'h1fff, 8'ha5);
   endtask
   // a write frozen in setup must hold its pins and not start the strobe
   task t_freeze;
      @(posedge i_clk_sys);
      i_req <= '{13'h0155, 8'h96, 1'b1};
      i_req_valid <= 1'b1;
      @(posedge i_clk_sys);
      i_req_valid <= 1'b0;
      i_ce <= 1'b0;
      repeat (3) @(negedge i_clk_sys);
      `CHK({o_ctl.we_n, o_ctl.sel_high, o_dq_oe}, 3'h5)
      `CHK(o_addr, 13'h0155)
      @(posedge i_clk_sys);
      i_ce <= 1'b1;
      read_chk(13'h0155, 8'h96);
   endtask
   initial
   begin
      i_clk_sys = 1'b0;
      forever #25 i_clk_sys = ~i_clk_sys;
   end
   // a hang anywhere is cut off at 2000 cycles, well beyond the fewer than 100 cycles the run needs
   always @(posedge i_clk_sys)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         n_mismatch++;
         wrap_up();
      end
   end
   initial
   begin
      i_rst_n = 1'b0;
      i_req_valid = 1'b0;
      i_low_supply = 1'b0;
      i_ce = 1'b1;
      i_req = '0;
      repeat (8) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      @(negedge i_clk_sys);
      t_reset();
      t_write_read();
      t_freeze();
      t_retain();
      wrap_up();
   end
endmodule
